/* File: logic/rkp_regs.sv */
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module rkp_regs
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // partition outputs
   output logic      [31:0] kernel_program_base,
   output logic             kernel_program_en,
   output logic             kernel_data_all
);
   ////////////////////////////////////////////////////////////////////
   logic [5:0]  base_field;
   logic [5:0]  next_base_field;
   logic [31:0] data_ram_size_value;
   logic [31:0] next_data_ram_size_value;
   logic [31:0] next_rdata;
   logic [31:0] base_word;
   logic [31:0] next_base_out;
   logic        next_en;
   logic        next_all;
   logic        base_zero;
   logic        base_over;

   // upper and low bits are constant zero
   assign base_word = {16'h0000, base_field, 10'h000};

   rkp_bound u_bound
   (
      .base_value (base_word),
      .size_value (data_ram_size_value),
      .base_zero  (base_zero),
      .base_over  (base_over)
   );

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_base_field          = base_field;
      next_data_ram_size_value = data_ram_size_value;
      if (reg_wr && reg_addr == rkp_pkg::ADDR_BASE)
      begin
         // only the six boundary bits capture
         next_base_field = reg_wdata[rkp_pkg::BASE_MSB:rkp_pkg::BASE_LSB];
      end
      if (reg_wr && reg_addr == rkp_pkg::ADDR_DRAM_SIZE)
      begin
         next_data_ram_size_value = reg_wdata;
      end
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (reg_rd)
      begin
         case (reg_addr)
            rkp_pkg::ADDR_BASE:      next_rdata = base_word;
            rkp_pkg::ADDR_DRAM_SIZE: next_rdata = data_ram_size_value;
            rkp_pkg::ADDR_STATUS:    next_rdata = {30'h0, base_over, base_zero};
            rkp_pkg::ADDR_GEOMETRY:  next_rdata = {rkp_pkg::PAGE_WORDS,
                                                   rkp_pkg::ROW_WORDS};
            default:                 next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // zero base: all ram to kernel data
   always_comb
   begin
      next_base_out = base_word;
      next_en       = !base_zero;
      next_all      = base_zero;
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         base_field          <= rkp_pkg::BASE_RESET;
         data_ram_size_value <= rkp_pkg::DRAM_SIZE_RESET;
         reg_rdata           <= 32'h0000_0000;
         kernel_program_base <= 32'h0000_0000;
         kernel_program_en   <= 1'b0;
         kernel_data_all     <= 1'b1;
      end
      else
      begin
         base_field          <= next_base_field;
         data_ram_size_value <= next_data_ram_size_value;
         reg_rdata           <= next_rdata;
         kernel_program_base <= next_base_out;
         kernel_program_en   <= next_en;
         kernel_data_all     <= next_all;
      end
   end

   ////////////////////////////////////////////////////////////////////
   AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(reg_rd) && $past(reg_addr) == rkp_pkg::ADDR_BASE
      |-> reg_rdata[31:16] == 16'h0000)
      else $error("upper base bits read non-zero");
   AST_WRITE_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
      reg_wr && reg_addr == rkp_pkg::ADDR_BASE ##1
      reg_rd && reg_addr == rkp_pkg::ADDR_BASE
      |=> reg_rdata[15:10] == $past(reg_wdata[15:10], 2))
      else $error("base field readback mismatch");
   AST_LOW_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
      kernel_program_base[9:0] == 10'h000)
      else $error("low base bits not zero");
   AST_RESET_ZERO: assert property (@(posedge ref_clk)
      $fell(sys_rst) |-> kernel_program_base == 32'h0 && kernel_data_all)
      else $error("base not zero after reset");
   AST_ALL_DATA: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ##1 (kernel_data_all == (kernel_program_base == 32'h0))
      && (kernel_program_en != kernel_data_all))
      else $error("partition flags disagree with base");
   AST_GEOMETRY: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(reg_rd) && $past(reg_addr) == rkp_pkg::ADDR_GEOMETRY
      |-> reg_rdata == 32'h0400_0080)
      else $error("geometry word wrong");
   AST_IGNORE_BITS: assert property (@(posedge ref_clk) disable iff (sys_rst)
      reg_wr && reg_addr == rkp_pkg::ADDR_BASE
      |-> ##2 kernel_program_base == {16'h0, $past(reg_wdata[15:10], 2),
                                      10'h0})
      else $error("write leaked outside bits 15..10");
   AST_OVER_FLAG: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(reg_rd) && $past(reg_addr) == rkp_pkg::ADDR_STATUS
      |-> reg_rdata[1] == ($past(base_word) > $past(data_ram_size_value)))
      else $error("over flag wrong");

   COV_BASE_SET: cover property (@(posedge ref_clk) disable iff (sys_rst)
      kernel_program_en);
   COV_BASE_CLEAR: cover property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(kernel_program_en));
   COV_OVER: cover property (@(posedge ref_clk) disable iff (sys_rst)
      base_over);
endmodule // rkp_regs

/* File: logic/rkp_pkg.sv */
package rkp_pkg;
   // register map
   localparam logic [7:0]  ADDR_BASE      = 8'h00;
   localparam logic [7:0]  ADDR_DRAM_SIZE = 8'h04;
   localparam logic [7:0]  ADDR_STATUS    = 8'h08;
   localparam logic [7:0]  ADDR_GEOMETRY  = 8'h0c;
   // field layout of the base register
   localparam int          BASE_MSB       = 15;
   localparam int          BASE_LSB       = 10;
   localparam int          BASE_W         = 6;
   localparam logic [5:0]  BASE_RESET     = 6'h00;
   localparam logic [31:0] DRAM_SIZE_RESET = 32'h0000_0000;
   // flash geometry
   localparam logic [15:0] PAGE_BYTES     = 16'h1000;
   localparam logic [15:0] PAGE_WORDS     = 16'h0400;
   localparam logic [15:0] ROW_BYTES      = 16'h0200;
   localparam logic [15:0] ROW_WORDS      = 16'h0080;
endpackage

/* File: logic/rkp_bound.sv */
`timescale 1ns/1ps
// compares the programmed base against the ram size
module rkp_bound
(
   // operands
   input  wire logic [31:0] base_value,
   input  wire logic [31:0] size_value,
   // result
   output logic             base_zero,
   output logic             base_over
);
   assign base_zero = (base_value == 32'h0000_0000);
   assign base_over = (base_value > size_value);
endmodule // rkp_bound

/* File: test/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); \
   num_errors++; end end
module tb;
   logic        ref_clk     = 1'b0;
   logic        sys_rst     = 1'b1;
   logic [7:0]  reg_addr    = 8'h00;
   logic [31:0] reg_wdata   = 32'h0000_0000;
   logic        reg_wr      = 1'b0;
   logic        reg_rd      = 1'b0;
   logic [31:0] reg_rdata, kpb, rd, b, s;
   logic [31:0] seed        = 32'h0000_005e;
   logic        kpe, kda;
   int          num_errors  = 0;
   int          checks_done = 0;
   rkp_regs rkp_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .kernel_program_base(kpb),
      .kernel_program_en(kpe), .kernel_data_all(kda));
   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // write then read the same address on back-to-back strobes
   task automatic wrrd(input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic end_sim;
      if (num_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // hang guard
   initial
   begin
      #400000 num_errors++;
      end_sim();
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rdr(rkp_pkg::ADDR_BASE, rd);
      `CHK(rd, 32'h0000_0000)
      `CHK(kda, 1'b1)
      `CHK(kpe, 1'b0)
      rdr(rkp_pkg::ADDR_GEOMETRY, rd);
      `CHK(rd, {rkp_pkg::PAGE_WORDS, rkp_pkg::ROW_WORDS})
      wr(rkp_pkg::ADDR_GEOMETRY, 32'hffff_ffff);
      rdr(rkp_pkg::ADDR_GEOMETRY, rd);
      `CHK(rd, {rkp_pkg::PAGE_WORDS, rkp_pkg::ROW_WORDS})
      rdr(8'h10, rd);
      `CHK(rd, 32'h0000_0000)
      // random base and size, all-ones and zero first
      for (int i = 0; i < 24; i++)
      begin
         seed = lfsr(seed);
         b = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0000 : seed;
         seed = lfsr(seed);
         s = seed & 32'h0000_ffff;
         if (s < (b & 32'h0000_fc00))
            s = b & 32'h0000_fc00;
         wr(rkp_pkg::ADDR_DRAM_SIZE, s);
         wr(rkp_pkg::ADDR_BASE, b);
         @(posedge ref_clk);
         #1 b = b & 32'h0000_fc00;
         `CHK(kpb, b)
         `CHK(kpe, b != 32'h0000_0000)
         `CHK(kda, b == 32'h0000_0000)
         wrrd(rkp_pkg::ADDR_BASE, b ^ (seed & 32'hffff_03ff), rd);
         `CHK(rd, b)
         rdr(rkp_pkg::ADDR_DRAM_SIZE, rd);
         `CHK(rd, s)
         rdr(rkp_pkg::ADDR_STATUS, rd);
         `CHK(rd, {30'h0, b > s, b == 32'h0000_0000})
      end
      // reset in mid-run
      wr(rkp_pkg::ADDR_BASE, 32'h0000_fc00);
      sys_rst <= 1'b1;
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      rdr(rkp_pkg::ADDR_BASE, rd);
      `CHK(rd, 32'h0000_0000)
      `CHK(kpb, 32'h0000_0000)
      `CHK(kda, 1'b1)
      end_sim();
   end
endmodule // tb
